//--- logic/pcs_pkg.sv
// package for the controller command slot handshake block
package pcs_pkg;
	localparam int SLOTS = 4;
	localparam int MEM_AW = 16;
	// control group bit positions, msb of a group is the first bit
	localparam int CTL_ERR_ACK = 3;
	localparam int CTL_COUPLED = 2;
	localparam int CTL_TRIGGER = 1;
	localparam int CTL_ABORT = 0;
	// status group bit positions
	localparam int STS_CMD_ERR = 3;
	localparam int STS_CTRL_ERR = 2;
	localparam int STS_BUSY = 1;
	localparam int STS_ABORT_BUSY = 0;
	// command block word offsets
	localparam logic [15:0] BLK_ERR_OFS = 16'h0000;
	localparam logic [15:0] BLK_CMD_OFS = 16'h0001;
	localparam logic [15:0] BLK_CONN_OFS = 16'h0002;
	localparam logic [15:0] BLK_PORT_OFS = 16'h0003;
	localparam logic [7:0] CONN_SIG = 8'h4B;
	localparam logic [15:0] CONN_MIN = 16'h4B01;
	localparam logic [15:0] CONN_MAX = 16'h4B63;
	localparam logic [15:0] NULL_ADDR = 16'h0000;
	// error codes written to block offset zero
	localparam logic [15:0] ERR_BAD_CMD = 16'h00A0;
	localparam logic [15:0] ERR_BAD_PORT = 16'h00A1;
	localparam logic [15:0] ERR_DUP_CONN = 16'h00A7;
	// command codes
	localparam logic [15:0] CMD_MAX = 16'h0010;
	localparam logic [15:0] CMD_OPEN_CONN = 16'h0001;
	localparam logic [15:0] PORT_MAX = 16'h0002;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam int EXEC_CYCLES = 8;

	typedef struct packed {
		logic req;
		logic we;
		logic [MEM_AW-1:0] addr;
		logic [15:0] wdata;
	} pcs_mem_req_t;

	typedef enum logic [7:0] {
		S_IDLE = 8'b0000_0001,
		S_RD_CONN = 8'b0000_0010,
		S_RD_CMD = 8'b0000_0100,
		S_RD_PORT = 8'b0000_1000,
		S_EXEC = 8'b0001_0000,
		S_WR_ERR = 8'b0010_0000,
		S_WAIT_ACK = 8'b0100_0000,
		S_WAIT_REL = 8'b1000_0000
	} pcs_state_t;
endpackage

//--- logic/pcs_slot_handshake.sv
// command slot handshake engine between controller image and command blocks
// Contract
// [R1] null or invalid block address raises controller and command error, no code written
// [R2] block invalid unless connection word high byte is the signature
// [R3] connection number must lie within the signature range inclusive
// [R4] after command error the slot stalls until its error acknowledge
// [R5] an errored slot never blocks the other slots
// [R6] free running timer counts in low byte of module status word
// [R7] controller holds coupled trigger until busy, then drops it
// [R8] coupled handshake completes only after trigger is seen low
// [R9] retriggered connection create reports duplicate connection code
// [R10] control word holds four 4-bit groups, one per slot
// [R11] slots may be triggered in any order
// [R12] each slot pointer word gives its command block address
// [R13] invalid command or port number returns an error code
// [R14] with flow control on, transmit waits for the handshake line
// [R15] control group bits: error ack, coupled, trigger, abort
// [R16] status group bits: command error, controller error, busy, abort busy
// [R17] error with valid block writes code to block word zero
// [R18] busy drops on success; error clears after ack seen then removed
`timescale 1ns/1ps
`default_nettype none
module pcs_slot_handshake #(
	parameter int SLOTS = pcs_pkg::SLOTS,
	parameter int MEM_AW = pcs_pkg::MEM_AW,
	parameter int EXEC_CYCLES = pcs_pkg::EXEC_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] slot_control_word,
	input wire logic [15:0] slot_block_pointer_1,
	input wire logic [15:0] slot_block_pointer_2,
	input wire logic [15:0] slot_block_pointer_3,
	input wire logic [15:0] slot_block_pointer_4,
	output logic [15:0] module_status_word,
	output logic [15:0] slot_status_word,
	output pcs_pkg::pcs_mem_req_t mem_req,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire logic [15:0] mem_rdata,
	input wire logic flow_ctrl_en,
	input wire logic handshake_in,
	input wire logic tx_req,
	output logic tx_go
);
	pcs_pkg::pcs_state_t st_q [SLOTS];
	logic [15:0] ptr [SLOTS];
	logic [3:0] ctl [SLOTS];
	logic [3:0] sts_q [SLOTS];
	logic [15:0] err_code_q [SLOTS];
	logic [15:0] cmd_q [SLOTS];
	logic [$clog2(EXEC_CYCLES+1)-1:0] exec_cnt_q [SLOTS];
	logic [SLOTS-1:0] conn_open_q;
	logic [SLOTS-1:0] want;
	logic [$clog2(SLOTS)-1:0] own_q;
	logic busy_q;
	logic [7:0] timer_q;
	logic [15:0] ctl_sync1_q;
	logic [15:0] ctl_sync2_q;
	logic [1:0] hs_sync_q;
	logic [15:0] ptr_sync1_q [SLOTS];
	logic [15:0] ptr_sync2_q [SLOTS];
	logic [SLOTS-1:0] mine;

	// group index 0 sits in the top nibble
	function automatic logic [3:0] nib(input logic [15:0] w, input int s);
		nib = w[15-4*s -: 4];
	endfunction

	// [R2] [R3] signature and range check
	function automatic logic conn_ok(input logic [15:0] w);
		conn_ok = (w[15:8] == pcs_pkg::CONN_SIG) && (w >= pcs_pkg::CONN_MIN)
			&& (w <= pcs_pkg::CONN_MAX);
	endfunction

	// block word address from slot pointer and word offset
	function automatic logic [MEM_AW-1:0] blk_addr(input logic [15:0] base, input logic [15:0] ofs);
		blk_addr = MEM_AW'(base + ofs);
	endfunction

	// controller image words come from another clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctl_sync1_q <= 16'h0000;
			ctl_sync2_q <= 16'h0000;
			hs_sync_q <= 2'b00;
		end else begin
			ctl_sync1_q <= slot_control_word;
			ctl_sync2_q <= ctl_sync1_q;
			hs_sync_q <= {hs_sync_q[0], handshake_in};
		end
	end

	// pointers settle before the trigger, which qualifies them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int s = 0; s < SLOTS; s++) begin
				ptr_sync1_q[s] <= pcs_pkg::NULL_ADDR;
				ptr_sync2_q[s] <= pcs_pkg::NULL_ADDR;
			end
		end else begin
			ptr_sync1_q[0] <= slot_block_pointer_1;
			ptr_sync1_q[1] <= slot_block_pointer_2;
			ptr_sync1_q[2] <= slot_block_pointer_3;
			ptr_sync1_q[3] <= slot_block_pointer_4;
			for (int s = 0; s < SLOTS; s++) begin
				ptr_sync2_q[s] <= ptr_sync1_q[s];
			end
		end
	end

	// [R12] slot pointers select the blocks
	assign ptr = ptr_sync2_q;

	// [R10] [R15] split control word into per-slot groups
	always_comb begin
		for (int s = 0; s < SLOTS; s++) begin
			ctl[s] = nib(ctl_sync2_q, s);
		end
	end

	// [R6] alive timer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timer_q <= 8'h00;
		end else begin
			timer_q <= timer_q + 8'h01;
		end
	end
	assign module_status_word = {8'h00, timer_q};

	// [R14] transmit gated by handshake line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_go <= 1'b0;
		end else begin
			tx_go <= tx_req && (!flow_ctrl_en || hs_sync_q[1]);
		end
	end

	// slots needing the shared block memory
	always_comb begin
		for (int s = 0; s < SLOTS; s++) begin
			want[s] = st_q[s] inside {pcs_pkg::S_RD_CONN, pcs_pkg::S_RD_CMD,
				pcs_pkg::S_RD_PORT, pcs_pkg::S_WR_ERR};
		end
	end

	// slot owning the memory transaction in flight
	always_comb begin
		for (int s = 0; s < SLOTS; s++) begin
			mine[s] = busy_q && (own_q == s[$clog2(SLOTS)-1:0]);
		end
	end

	// [R5] [R11] memory arbiter, one owner per transaction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			own_q <= '0;
		end else if (!busy_q) begin
			for (int s = SLOTS - 1; s >= 0; s--) begin
				if (want[s]) begin
					busy_q <= 1'b1;
					own_q <= s[$clog2(SLOTS)-1:0];
				end
			end
		end else if (mem_rvalid || (mem_req.we && mem_gnt)) begin
			busy_q <= 1'b0;
		end
	end

	logic issued_q;
	always_ff @(posedge clk) begin
		if (sys_rst || !busy_q || mem_rvalid) begin
			issued_q <= 1'b0;
		end else if (mem_gnt) begin
			issued_q <= 1'b1;
		end
	end

	always_comb begin
		mem_req = '0;
		if (busy_q && !issued_q) begin
			mem_req.req = 1'b1;
			unique case (st_q[own_q])
				pcs_pkg::S_RD_CONN: mem_req.addr = blk_addr(ptr[own_q], pcs_pkg::BLK_CONN_OFS);
				pcs_pkg::S_RD_CMD: mem_req.addr = blk_addr(ptr[own_q], pcs_pkg::BLK_CMD_OFS);
				pcs_pkg::S_RD_PORT: mem_req.addr = blk_addr(ptr[own_q], pcs_pkg::BLK_PORT_OFS);
				// [R17] error code into block word zero
				pcs_pkg::S_WR_ERR: begin
					mem_req.we = 1'b1;
					mem_req.addr = blk_addr(ptr[own_q], pcs_pkg::BLK_ERR_OFS);
					mem_req.wdata = err_code_q[own_q];
				end
				default: mem_req.req = 1'b0;
			endcase
		end
	end

	// per-slot state machines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int s = 0; s < SLOTS; s++) begin
				st_q[s] <= pcs_pkg::S_IDLE;
				sts_q[s] <= pcs_pkg::NIB_ZERO;
				err_code_q[s] <= 16'h0000;
				cmd_q[s] <= 16'h0000;
				exec_cnt_q[s] <= '0;
			end
			conn_open_q <= '0;
		end else begin
			for (int s = 0; s < SLOTS; s++) begin
				unique case (st_q[s])
					pcs_pkg::S_IDLE: begin
						if (ctl[s][pcs_pkg::CTL_TRIGGER]) begin
							sts_q[s][pcs_pkg::STS_BUSY] <= 1'b1;
							// [R1] null pointer fails at once
							if (ptr[s] == pcs_pkg::NULL_ADDR) begin
								sts_q[s][pcs_pkg::STS_CMD_ERR] <= 1'b1;
								sts_q[s][pcs_pkg::STS_CTRL_ERR] <= 1'b1;
								st_q[s] <= pcs_pkg::S_WAIT_ACK;
							end else begin
								st_q[s] <= pcs_pkg::S_RD_CONN;
							end
						end
					end
					pcs_pkg::S_RD_CONN: if (mine[s] && mem_rvalid) begin
						// [R1] bad block, no code written
						if (!conn_ok(mem_rdata)) begin
							sts_q[s][pcs_pkg::STS_CMD_ERR] <= 1'b1;
							sts_q[s][pcs_pkg::STS_CTRL_ERR] <= 1'b1;
							st_q[s] <= pcs_pkg::S_WAIT_ACK;
						end else begin
							st_q[s] <= pcs_pkg::S_RD_CMD;
						end
					end
					pcs_pkg::S_RD_CMD: if (mine[s] && mem_rvalid) begin
						cmd_q[s] <= mem_rdata;
						st_q[s] <= pcs_pkg::S_RD_PORT;
					end
					pcs_pkg::S_RD_PORT: if (mine[s] && mem_rvalid) begin
						// [R13] command and port range checks
						if (cmd_q[s] > pcs_pkg::CMD_MAX) begin
							err_code_q[s] <= pcs_pkg::ERR_BAD_CMD;
							st_q[s] <= pcs_pkg::S_WR_ERR;
						end else if (mem_rdata > pcs_pkg::PORT_MAX) begin
							err_code_q[s] <= pcs_pkg::ERR_BAD_PORT;
							st_q[s] <= pcs_pkg::S_WR_ERR;
						// [R9] second open on same slot is a duplicate
						end else if (cmd_q[s] == pcs_pkg::CMD_OPEN_CONN && conn_open_q[s]) begin
							err_code_q[s] <= pcs_pkg::ERR_DUP_CONN;
							st_q[s] <= pcs_pkg::S_WR_ERR;
						end else begin
							if (cmd_q[s] == pcs_pkg::CMD_OPEN_CONN) begin
								conn_open_q[s] <= 1'b1;
							end
							exec_cnt_q[s] <= '0;
							st_q[s] <= pcs_pkg::S_EXEC;
						end
					end
					pcs_pkg::S_EXEC: begin
						if (32'(exec_cnt_q[s]) < EXEC_CYCLES) begin
							exec_cnt_q[s] <= exec_cnt_q[s] + 1'b1;
						// [R8] coupled completion waits for trigger low
						end else if (!ctl[s][pcs_pkg::CTL_COUPLED]
								|| !ctl[s][pcs_pkg::CTL_TRIGGER]) begin
							// [R18] busy drops on success
							sts_q[s][pcs_pkg::STS_BUSY] <= 1'b0;
							st_q[s] <= pcs_pkg::S_WAIT_REL;
						end
					end
					pcs_pkg::S_WR_ERR: if (mine[s] && mem_gnt) begin
						sts_q[s][pcs_pkg::STS_CMD_ERR] <= 1'b1;
						st_q[s] <= pcs_pkg::S_WAIT_ACK;
					end
					// [R4] stall until acknowledge
					pcs_pkg::S_WAIT_ACK: if (ctl[s][pcs_pkg::CTL_ERR_ACK]) begin
						sts_q[s][pcs_pkg::STS_BUSY] <= 1'b0;
						st_q[s] <= pcs_pkg::S_WAIT_REL;
					end
					// [R18] errors clear once ack removed; no retrigger on held trigger
					pcs_pkg::S_WAIT_REL: if (!ctl[s][pcs_pkg::CTL_ERR_ACK]
							&& !ctl[s][pcs_pkg::CTL_TRIGGER]) begin
						sts_q[s] <= pcs_pkg::NIB_ZERO;
						st_q[s] <= pcs_pkg::S_IDLE;
					end
					default: st_q[s] <= pcs_pkg::S_IDLE;
				endcase
			end
		end
	end

	// [R16] status word groups, slot 1 in top nibble
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_status_word <= 16'h0000;
		end else begin
			slot_status_word <= {sts_q[0], sts_q[1], sts_q[2], sts_q[3]};
		end
	end
endmodule
`default_nettype wire

//--- verif/pcs_chk_sva.sv
// assertion checker for the command slot handshake ports
`timescale 1ns/1ps
`default_nettype none
module pcs_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] slot_control_word,
	input wire logic [15:0] module_status_word,
	input wire logic [15:0] slot_status_word,
	input wire pcs_pkg::pcs_mem_req_t mem_req,
	input wire logic mem_gnt
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic [15:0] s = slot_status_word;
	wire logic [15:0] c = slot_control_word;
	wire logic wr = mem_req.req && mem_req.we;
	a_timer_step: assert property (!$past(sys_rst) |-> module_status_word[7:0] ==
		8'($past(module_status_word[7:0]) + 8'h01)) else $error("timer did not step");
	a_abort_idle: assert property ((s & 16'h1111) == 16'h0000)
		else $error("abort busy raised");
	a_ctrl_err_pair: assert property ((s & ~(s >> 1) & 16'h4444) == 16'h0000)
		else $error("controller error without command error");
	a_err_stall: assert property ((s[15] && !c[15])[*8] |=> s[15])
		else $error("command error left without acknowledge");
	a_trig_busy: assert property ((!c[13] && !c[15])[*4] ##1 (c[13] && s[15:12] == 4'h0)
		|-> ##[1:8] (s[13] || s[15])) else $error("trigger not answered");
	a_busy_hold: assert property ((c[15:12] == 4'h6)[*4] ##0 s[13] |=> s[13])
		else $error("busy dropped while trigger held");
	a_drop_rel: assert property ($fell(s[13]) && $past(c[14], 4) && !$past(s[15])
		|-> !$past(c[13], 4)) else $error("coupled done before trigger low");
	a_no_null_wr: assert property (wr |-> mem_req.addr != pcs_pkg::NULL_ADDR)
		else $error("error code written at null address");
	a_code_set: assert property (wr |-> mem_req.wdata inside {16'h00A0, 16'h00A1, 16'h00A7})
		else $error("unknown error code written");
	a_err_flag: assert property (wr && mem_gnt |-> ##[1:3] ((s & 16'h8888) != 16'h0000))
		else $error("code written without command error");
	c_cmd_err: cover property (s[15:12] == 4'hA);
	c_ctrl_err: cover property (s[15:12] == 4'hE);
	c_done: cover property ($fell(s[13]) && !s[15]);
endmodule
bind pcs_slot_handshake pcs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.slot_control_word(slot_control_word), .module_status_word(module_status_word),
	.slot_status_word(slot_status_word), .mem_req(mem_req), .mem_gnt(mem_gnt));
`default_nettype wire

//--- verif/pcs_mem_model.sv
// controller variable memory holding the command blocks
`timescale 1ns/1ps
`default_nettype none
module pcs_mem_model (
	input wire logic clk,
	input wire logic slow,
	input wire pcs_pkg::pcs_mem_req_t mem_req,
	output logic mem_gnt,
	output logic mem_rvalid,
	output logic [15:0] mem_rdata
);
	logic [15:0] m [0:255];
	logic [15:0] rd_q = 16'h0000;
	logic tick_q = 1'b0;
	// words served from the pointed block
	assign mem_gnt = mem_req.req && (!slow || tick_q);
	always @(posedge clk) begin
		tick_q <= !tick_q;
		mem_rvalid <= mem_gnt && !mem_req.we;
		if (mem_gnt && mem_req.we) m[mem_req.addr[7:0]] <= mem_req.wdata;
		if (mem_gnt && !mem_req.we) rd_q <= m[mem_req.addr[7:0]];
	end
	// idle bus shows the inverted last word
	assign mem_rdata = mem_rvalid ? rd_q : ~rd_q;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the command slot handshake
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slow = 1'b0;
	logic fc = 1'b0;
	logic hs = 1'b0;
	logic txr = 1'b0;
	logic [15:0] ctl = 16'h0000;
	logic [15:0] p [4] = '{default: 16'h0000};
	logic [15:0] msw, ssw, rdata;
	logic gnt, rv, txg;
	pcs_pkg::pcs_mem_req_t req;
	int mismatches = 0;
	int checked = 0;
	always #4 clk = ~clk;
	pcs_slot_handshake uut (.clk(clk), .sys_rst(sys_rst), .slot_control_word(ctl),
		.slot_block_pointer_1(p[0]), .slot_block_pointer_2(p[1]),
		.slot_block_pointer_3(p[2]), .slot_block_pointer_4(p[3]),
		.module_status_word(msw), .slot_status_word(ssw), .mem_req(req), .mem_gnt(gnt),
		.mem_rvalid(rv), .mem_rdata(rdata), .flow_ctrl_en(fc), .handshake_in(hs),
		.tx_req(txr), .tx_go(txg));
	pcs_mem_model mem (.clk(clk), .slow(slow), .mem_req(req), .mem_gnt(gnt),
		.mem_rvalid(rv), .mem_rdata(rdata));
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [3:0] nib(int s);
		return ssw[15-4*s -: 4];
	endfunction
	task automatic setn(int s, logic [3:0] n);
		@(posedge clk);
		ctl[15-4*s -: 4] <= n;
	endtask
	task automatic waitn(int s, logic [3:0] w);
		int i;
		i = 0;
		do begin @(negedge clk); i++; end while (i < 300 && nib(s) !== w);
		`CHK("slot nibble", w, nib(s))
		if (nib(s) !== w) final_report();
	endtask
	task automatic start(int s, logic [15:0] a, logic [15:0] cmd, logic [15:0] cn,
		logic [15:0] pt, logic [3:0] md);
		mem.m[a[7:0]] = 16'h0000;
		mem.m[a[7:0]+8'h01] = cmd;
		mem.m[a[7:0]+8'h02] = cn;
		mem.m[a[7:0]+8'h03] = pt;
		@(posedge clk);
		p[s] <= a;
		setn(s, md);
	endtask
	task automatic done_ok(int s, logic [3:0] md);
		waitn(s, 4'h2);
		// coupled keeps mode, drops trigger
		if (md[2]) begin
			repeat (60) @(negedge clk);
			`CHK("coupled hold", 4'h2, nib(s))
			setn(s, 4'h4);
		end
		waitn(s, 4'h0);
		repeat (8) @(negedge clk);
		`CHK("no retrigger", 4'h0, nib(s))
		setn(s, 4'h0);
		$display("test slot %0d done", s);
	endtask
	task automatic done_err(int s, logic [3:0] e, logic [15:0] a, logic [15:0] code);
		waitn(s, e);
		`CHK("error word", code, mem.m[a[7:0]])
		setn(s, 4'h8);
		waitn(s, e & 4'hD);
		setn(s, 4'h0);
		waitn(s, 4'h0);
		$display("test slot %0d error done", s);
	endtask
	initial begin
		logic [7:0] t0;
		int k;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(negedge clk);
		`CHK("status after reset", 16'h0000, ssw)
		`CHK("tx after reset", 1'b0, txg)
		`CHK("status high byte", 8'h00, msw[15:8])
		t0 = msw[7:0];
		repeat (10) @(negedge clk);
		`CHK("timer", 8'(t0 + 8'h0A), msw[7:0])
		for (k = 0; k < 8; k++) begin
			@(posedge clk);
			{fc, hs, txr} <= 3'(k);
			repeat (5) @(negedge clk);
			`CHK("tx gate", txr & (~fc | hs), txg)
		end
		$display("test flow done");
		start(0, 16'h0010, 16'h0002, 16'h4B01, 16'h0001, 4'h6);
		done_ok(0, 4'h6);
		start(1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h2);
		done_err(1, 4'hE, 16'h0000, 16'h0000);
		start(2, 16'h0020, 16'h0002, 16'h4C01, 16'h0001, 4'h2);
		done_err(2, 4'hE, 16'h0020, 16'h0000);
		start(3, 16'h0030, 16'h0002, 16'h4B64, 16'h0001, 4'h6);
		done_err(3, 4'hE, 16'h0030, 16'h0000);
		slow <= 1'b1;
		start(2, 16'h0040, 16'h0011, 16'h4B63, 16'h0001, 4'h2);
		done_err(2, 4'hA, 16'h0040, 16'h00A0);
		start(3, 16'h0050, 16'h0002, 16'h4B02, 16'h0003, 4'h2);
		done_err(3, 4'hA, 16'h0050, 16'h00A1);
		start(1, 16'h0060, 16'h0001, 16'h4B05, 16'h0001, 4'h2);
		done_ok(1, 4'h2);
		start(1, 16'h0060, 16'h0001, 16'h4B05, 16'h0001, 4'h2);
		done_err(1, 4'hA, 16'h0060, 16'h00A7);
		start(0, 16'h0070, 16'h0011, 16'h4B07, 16'h0001, 4'h6);
		waitn(0, 4'hA);
		start(3, 16'h0080, 16'h0002, 16'h4B08, 16'h0002, 4'h2);
		done_ok(3, 4'h2);
		done_err(0, 4'hA, 16'h0070, 16'h00A0);
		final_report();
	end
endmodule
`default_nettype wire
